//--- hw/fpsi_top.sv
// front panel status indicator: ahb-lite registers, seven segment sequence, status leds
// Behaviour
// [RULE_01] node address is upper switch nibble above lower switch nibble
// [RULE_02] switches are taken only after power-up or software reset, never between
// [RULE_03] one seven segment digit shows servo status, network state and alarms
// [RULE_04] system check glyph stays until startup completes, then network state shows
// [RULE_05] an active alarm shows its code after the network state glyph
// [RULE_06] distinct glyphs for no controller, pre-op, safe-op and bootstrap
// [RULE_07] distinct glyphs for test mode, cpu watchdog failure and parameter init
// [RULE_08] servo led dark when not ready, blinking ready-off, steady ready-on
// [RULE_09] each link led follows its own port's link independently
// [RULE_10] blink toggles every 200 ms, flicker toggles every 50 ms
// [RULE_11] single flash is 200 ms on then 1000 ms off, repeating
// [RULE_12] run led off in init, blink pre-op, flash safe-op, on operational
// [RULE_13] link led off without link, on when idle, flickering with traffic
// [RULE_14] with an alarm the digit cycles network state then alarm digits, one per second
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "fpsi_consts.svh"
module fpsi_top #(
	parameter int TICK_CYCLES = `FPSI_FLICKER_CYC
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// rotary address switches
	input wire logic [3:0] upper_address_switch,
	input wire logic [3:0] lower_address_switch,
	// port link status
	input wire logic in_port_link,
	input wire logic in_port_activity,
	input wire logic out_port_link,
	input wire logic out_port_activity,
	// panel outputs
	output logic [6:0] segment,
	output logic servo_on_led,
	output logic run_led,
	output logic in_link_led,
	output logic out_link_led,
	output logic irq
);

	logic tick;
	logic flicker;
	logic blink;
	logic flash;

	// shared pattern timing for every indicator
	fpsi_blink #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_blink (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(tick),
		.flicker(flicker),
		.blink(blink),
		.flash(flash)
	);

	// hex digit to glyph
	function automatic logic [6:0] hex_glyph(input logic [3:0] d);
		logic [6:0] g;
		g = 7'h00;
		unique case (d)
			4'h0: g = 7'h3f;
			4'h1: g = 7'h06;
			4'h2: g = 7'h5b;
			4'h3: g = 7'h4f;
			4'h4: g = 7'h66;
			4'h5: g = 7'h6d;
			4'h6: g = 7'h7d;
			4'h7: g = 7'h07;
			4'h8: g = 7'h7f;
			4'h9: g = 7'h6f;
			4'ha: g = 7'h77;
			4'hb: g = 7'h7c;
			4'hc: g = 7'h39;
			4'hd: g = 7'h5e;
			4'he: g = 7'h79;
			4'hf: g = 7'h71;
		endcase
		return g;
	endfunction

	// bus state
	logic wr_pend;
	logic rd_pend;
	logic [7:0] addr_q;
	logic next_wr_pend;
	logic next_rd_pend;
	logic [7:0] next_addr_q;
	logic next_hreadyout;
	logic [31:0] next_hrdata;
	logic [31:0] rd_mux;
	logic accept;

	// register state
	logic sample_pend;
	logic started;
	logic [7:0] node_addr;
	fpsi_pkg::fpsi_comm_t comm;
	logic [4:0] servo;
	logic [16:0] alarm;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;
	logic in_link_q;
	logic out_link_q;
	logic next_sample_pend;
	logic next_started;
	logic [7:0] next_node_addr;
	fpsi_pkg::fpsi_comm_t next_comm;
	logic [4:0] next_servo;
	logic [16:0] next_alarm;
	logic [2:0] next_irq_status;
	logic [2:0] next_irq_mask;
	logic [2:0] events;
	logic wr_ctrl;

	// display and led state
	fpsi_pkg::fpsi_phase_t phase;
	fpsi_pkg::fpsi_phase_t next_phase;
	logic [4:0] step_cnt;
	logic [4:0] next_step_cnt;
	logic [6:0] next_segment;
	logic [6:0] net_glyph;
	logic next_servo_on_led;
	logic next_run_led;
	logic next_in_link_led;
	logic next_out_link_led;
	logic next_irq;

	// read mux; reserved bits read zero, unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (addr_q)
			`FPSI_OFF_CTRL: rd_mux[`FPSI_CTRL_STARTED] = started;
			`FPSI_OFF_NET: rd_mux[2:0] = comm;
			`FPSI_OFF_SERVO: rd_mux[4:0] = servo;
			`FPSI_OFF_ALARM: rd_mux[16:0] = alarm;
			`FPSI_OFF_NODE: rd_mux[7:0] = node_addr;
			`FPSI_OFF_IRQ_STATUS: rd_mux[2:0] = irq_status;
			`FPSI_OFF_IRQ_MASK: rd_mux[2:0] = irq_mask;
			`FPSI_OFF_PANEL: rd_mux[11:0] = {in_link_led, out_link_led, run_led,
				servo_on_led, 1'b0, segment};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// bus: writes have no wait state, reads add one so a write just before is seen
	always_comb begin
		accept = hsel && hready && htrans[1];
		next_wr_pend = accept && hwrite;
		next_rd_pend = accept && !hwrite;
		next_addr_q = accept ? haddr[7:0] : addr_q;
		next_hreadyout = !(accept && !hwrite);
		next_hrdata = rd_pend ? rd_mux : hrdata;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q <= 8'h00;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else begin
			wr_pend <= next_wr_pend;
			rd_pend <= next_rd_pend;
			addr_q <= next_addr_q;
			hreadyout <= next_hreadyout;
			hrdata <= next_hrdata;
			hresp <= 1'b0;
		end
	end

	// registers, switch capture and interrupt status
	always_comb begin
		wr_ctrl = wr_pend && (addr_q == `FPSI_OFF_CTRL);
		next_started = started;
		next_comm = comm;
		next_servo = servo;
		next_alarm = alarm;
		next_irq_mask = irq_mask;
		next_node_addr = node_addr;
		// capture happens once, in the cycle after reset release or soft reset
		next_sample_pend = 1'b0;
		if (sample_pend) begin
			next_node_addr = {upper_address_switch, lower_address_switch}; // RULE_01 RULE_02
		end
		if (wr_ctrl) begin
			next_started = hwdata[`FPSI_CTRL_STARTED];
		end
		if (wr_ctrl && hwdata[`FPSI_CTRL_SOFT_RESET]) begin
			next_sample_pend = 1'b1; // RULE_02
			next_started = 1'b0; // RULE_04
		end
		if (wr_pend && (addr_q == `FPSI_OFF_NET)) begin
			next_comm = fpsi_pkg::fpsi_comm_t'(hwdata[2:0]);
		end
		if (wr_pend && (addr_q == `FPSI_OFF_SERVO)) begin
			next_servo = hwdata[4:0];
		end
		if (wr_pend && (addr_q == `FPSI_OFF_ALARM)) begin
			next_alarm = hwdata[16:0];
		end
		if (wr_pend && (addr_q == `FPSI_OFF_IRQ_MASK)) begin
			next_irq_mask = hwdata[2:0];
		end
		events[`FPSI_IRQ_ADDR] = sample_pend;
		events[`FPSI_IRQ_IN_LINK] = in_port_link != in_link_q;
		events[`FPSI_IRQ_OUT_LINK] = out_port_link != out_link_q;
		next_irq_status = irq_status;
		if (wr_pend && (addr_q == `FPSI_OFF_IRQ_STATUS)) begin
			next_irq_status = irq_status & ~hwdata[2:0];
		end
		// an event in the clearing cycle survives
		next_irq_status = next_irq_status | events;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sample_pend <= 1'b1;
			started <= 1'b0;
			node_addr <= `FPSI_RST_NODE;
			comm <= fpsi_pkg::FPSI_COMM_NONE;
			servo <= `FPSI_RST_SERVO;
			alarm <= `FPSI_RST_ALARM;
			irq_status <= `FPSI_RST_IRQ;
			irq_mask <= `FPSI_RST_IRQ;
			in_link_q <= 1'b0;
			out_link_q <= 1'b0;
		end else begin
			sample_pend <= next_sample_pend;
			started <= next_started;
			node_addr <= next_node_addr;
			comm <= next_comm;
			servo <= next_servo;
			alarm <= next_alarm;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			in_link_q <= in_port_link;
			out_link_q <= out_port_link;
		end
	end

	// network state glyph; fault and mode glyphs take priority over network state
	always_comb begin
		net_glyph = `FPSI_SEG_NOCTRL;
		if (servo[`FPSI_SERVO_CPU_WD]) begin
			net_glyph = `FPSI_SEG_CPU; // RULE_07
		end else if (servo[`FPSI_SERVO_PARAM_INIT]) begin
			net_glyph = `FPSI_SEG_INIT; // RULE_07
		end else if (servo[`FPSI_SERVO_TEST]) begin
			net_glyph = `FPSI_SEG_TEST; // RULE_07
		end else begin
			case (comm)
				fpsi_pkg::FPSI_COMM_PREOP: net_glyph = `FPSI_SEG_PREOP; // RULE_06
				fpsi_pkg::FPSI_COMM_SAFEOP: net_glyph = `FPSI_SEG_SAFEOP; // RULE_06
				fpsi_pkg::FPSI_COMM_BOOT: net_glyph = `FPSI_SEG_BOOT; // RULE_06
				fpsi_pkg::FPSI_COMM_OP: begin
					// connected: the digit shows servo status
					if (servo[`FPSI_SERVO_READY] && servo[`FPSI_SERVO_ON]) begin
						net_glyph = `FPSI_SEG_SRV_ON; // RULE_03
					end else if (servo[`FPSI_SERVO_READY]) begin
						net_glyph = `FPSI_SEG_SRV_RDY; // RULE_03
					end else begin
						net_glyph = `FPSI_SEG_SRV_OFF; // RULE_03
					end
				end
				default: net_glyph = `FPSI_SEG_NOCTRL; // RULE_06
			endcase
		end
	end

	// display sequence: without an alarm the phase rests on the network glyph
	always_comb begin
		next_phase = phase;
		next_step_cnt = step_cnt;
		if (!started || !alarm[`FPSI_ALARM_ACTIVE]) begin
			next_phase = fpsi_pkg::FPSI_PH_NET; // RULE_05
			next_step_cnt = 5'h00;
		end else if (tick) begin
			next_step_cnt = step_cnt + 5'h01;
			if (step_cnt == `FPSI_STEP_TICKS - 5'h01) begin
				next_step_cnt = 5'h00;
				unique case (phase)
					fpsi_pkg::FPSI_PH_NET: next_phase = fpsi_pkg::FPSI_PH_ALM; // RULE_14
					fpsi_pkg::FPSI_PH_ALM: next_phase = fpsi_pkg::FPSI_PH_D2; // RULE_14
					fpsi_pkg::FPSI_PH_D2: next_phase = fpsi_pkg::FPSI_PH_D1; // RULE_14
					fpsi_pkg::FPSI_PH_D1: next_phase = fpsi_pkg::FPSI_PH_D0; // RULE_14
					fpsi_pkg::FPSI_PH_D0: next_phase = fpsi_pkg::FPSI_PH_DET; // RULE_14
					fpsi_pkg::FPSI_PH_DET: next_phase = fpsi_pkg::FPSI_PH_NET; // RULE_14
				endcase
			end
		end
		// the glyph follows the phase being entered so it lines up with the step
		next_segment = `FPSI_SEG_CHECK; // RULE_04
		if (started) begin
			unique case (next_phase)
				fpsi_pkg::FPSI_PH_NET: next_segment = net_glyph; // RULE_03
				fpsi_pkg::FPSI_PH_ALM: next_segment = `FPSI_SEG_ALARM; // RULE_05
				fpsi_pkg::FPSI_PH_D2: next_segment = hex_glyph(alarm[15:12]); // RULE_05
				fpsi_pkg::FPSI_PH_D1: next_segment = hex_glyph(alarm[11:8]); // RULE_05
				fpsi_pkg::FPSI_PH_D0: next_segment = hex_glyph(alarm[7:4]); // RULE_05
				fpsi_pkg::FPSI_PH_DET: next_segment = hex_glyph(alarm[3:0]); // RULE_05
			endcase
		end
	end

	// leds and interrupt line
	always_comb begin
		next_servo_on_led = 1'b0; // RULE_08
		if (servo[`FPSI_SERVO_READY]) begin
			next_servo_on_led = servo[`FPSI_SERVO_ON] ? 1'b1 : blink; // RULE_08
		end
		case (comm)
			fpsi_pkg::FPSI_COMM_PREOP: next_run_led = blink; // RULE_12
			fpsi_pkg::FPSI_COMM_SAFEOP: next_run_led = flash; // RULE_12
			fpsi_pkg::FPSI_COMM_OP: next_run_led = 1'b1; // RULE_12
			default: next_run_led = 1'b0; // RULE_12
		endcase
		// activity alone without link keeps the led dark
		next_in_link_led = in_port_link && (!in_port_activity || flicker); // RULE_09 RULE_13
		next_out_link_led = out_port_link && (!out_port_activity || flicker); // RULE_09 RULE_13
		next_irq = |(next_irq_status & next_irq_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= fpsi_pkg::FPSI_PH_NET;
			step_cnt <= 5'h00;
			segment <= `FPSI_RST_SEG;
			servo_on_led <= 1'b0;
			run_led <= 1'b0;
			in_link_led <= 1'b0;
			out_link_led <= 1'b0;
			irq <= 1'b0;
		end else begin
			phase <= next_phase;
			step_cnt <= next_step_cnt;
			segment <= next_segment;
			servo_on_led <= next_servo_on_led;
			run_led <= next_run_led;
			in_link_led <= next_in_link_led;
			out_link_led <= next_out_link_led;
			irq <= next_irq;
		end
	end

endmodule

//--- hw/fpsi_consts.svh
// constants of the front panel status indicator: offsets, fields, resets, timing, glyphs
`ifndef FPSI_CONSTS_SVH
`define FPSI_CONSTS_SVH

// register byte offsets
`define FPSI_OFF_CTRL 8'h00
`define FPSI_OFF_NET 8'h04
`define FPSI_OFF_SERVO 8'h08
`define FPSI_OFF_ALARM 8'h0c
`define FPSI_OFF_NODE 8'h10
`define FPSI_OFF_IRQ_STATUS 8'h14
`define FPSI_OFF_IRQ_MASK 8'h18
`define FPSI_OFF_PANEL 8'h1c

// control field positions
`define FPSI_CTRL_STARTED 0
`define FPSI_CTRL_SOFT_RESET 1
// servo field positions
`define FPSI_SERVO_READY 0
`define FPSI_SERVO_ON 1
`define FPSI_SERVO_TEST 2
`define FPSI_SERVO_CPU_WD 3
`define FPSI_SERVO_PARAM_INIT 4
// alarm field positions
`define FPSI_ALARM_ACTIVE 16
`define FPSI_ALARM_CODE_LSB 4
`define FPSI_ALARM_CODE_MSB 15
// interrupt bits
`define FPSI_IRQ_ADDR 0
`define FPSI_IRQ_IN_LINK 1
`define FPSI_IRQ_OUT_LINK 2
`define FPSI_IRQ_BITS 3

// reset values
`define FPSI_RST_NODE 8'h00
`define FPSI_RST_COMM 3'h0
`define FPSI_RST_SERVO 5'h00
`define FPSI_RST_ALARM 17'h0_0000
`define FPSI_RST_IRQ 3'h0
`define FPSI_RST_SEG 7'h7f

// timing
`define FPSI_CLK_HZ 20000000
`define FPSI_FLICKER_MS 50
`define FPSI_BLINK_MS 200
`define FPSI_FLASH_ON_MS 200
`define FPSI_FLASH_OFF_MS 1000
`define FPSI_STEP_MS 1000
`define FPSI_FLICKER_CYC ((`FPSI_CLK_HZ / 1000) * `FPSI_FLICKER_MS)
`define FPSI_BLINK_TICKS 5'(`FPSI_BLINK_MS / `FPSI_FLICKER_MS)
`define FPSI_FLASH_ON_TICKS 5'(`FPSI_FLASH_ON_MS / `FPSI_FLICKER_MS)
`define FPSI_FLASH_TICKS 5'((`FPSI_FLASH_ON_MS + `FPSI_FLASH_OFF_MS) / `FPSI_FLICKER_MS)
`define FPSI_STEP_TICKS 5'(`FPSI_STEP_MS / `FPSI_FLICKER_MS)

// seven segment glyphs, bit order g f e d c b a, active high
`define FPSI_SEG_CHECK 7'h7f
`define FPSI_SEG_NOCTRL 7'h40
`define FPSI_SEG_PREOP 7'h73
`define FPSI_SEG_SAFEOP 7'h6d
`define FPSI_SEG_BOOT 7'h7c
`define FPSI_SEG_TEST 7'h78
`define FPSI_SEG_CPU 7'h79
`define FPSI_SEG_INIT 7'h30
`define FPSI_SEG_SRV_ON 7'h5e
`define FPSI_SEG_SRV_RDY 7'h50
`define FPSI_SEG_SRV_OFF 7'h08
`define FPSI_SEG_ALARM 7'h77

`endif

//--- hw/fpsi_pkg.sv
// types of the front panel status indicator
package fpsi_pkg;

	// network state as software reports it
	typedef enum logic [2:0] {
		FPSI_COMM_NONE = 3'h0,
		FPSI_COMM_INIT = 3'h1,
		FPSI_COMM_PREOP = 3'h2,
		FPSI_COMM_SAFEOP = 3'h3,
		FPSI_COMM_OP = 3'h4,
		FPSI_COMM_BOOT = 3'h5
	} fpsi_comm_t;

	// display sequence phases
	typedef enum logic [5:0] {
		FPSI_PH_NET = 6'h01,
		FPSI_PH_ALM = 6'h02,
		FPSI_PH_D2 = 6'h04,
		FPSI_PH_D1 = 6'h08,
		FPSI_PH_D0 = 6'h10,
		FPSI_PH_DET = 6'h20
	} fpsi_phase_t;

endpackage

//--- hw/fpsi_blink.sv
// blink pattern generator: 50 ms tick, flicker, blink and single flash levels
`timescale 1ns/1ns
`include "fpsi_consts.svh"
module fpsi_blink #(
	parameter int TICK_CYCLES = `FPSI_FLICKER_CYC
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// pattern outputs
	output logic tick,
	output logic flicker,
	output logic blink,
	output logic flash
);

	logic [23:0] cnt;
	logic [4:0] blink_cnt;
	logic [4:0] flash_cnt;
	logic next_tick;
	logic next_flicker;
	logic next_blink;
	logic next_flash;
	logic [23:0] next_cnt;
	logic [4:0] next_blink_cnt;
	logic [4:0] next_flash_cnt;

	// one prescaler feeds every pattern so all leds stay in phase
	always_comb begin
		next_cnt = cnt + 24'h00_0001;
		next_tick = 1'b0;
		next_flicker = flicker;
		next_blink_cnt = blink_cnt;
		next_blink = blink;
		next_flash_cnt = flash_cnt;
		if (cnt == 24'(TICK_CYCLES - 1)) begin
			next_cnt = 24'h00_0000;
			next_tick = 1'b1;
			next_flicker = !flicker; // RULE_10
			next_blink_cnt = blink_cnt + 5'h01;
			if (blink_cnt == `FPSI_BLINK_TICKS - 5'h01) begin
				next_blink_cnt = 5'h00;
				next_blink = !blink; // RULE_10
			end
			next_flash_cnt = flash_cnt + 5'h01;
			if (flash_cnt == `FPSI_FLASH_TICKS - 5'h01) begin
				next_flash_cnt = 5'h00;
			end
		end
		next_flash = (next_flash_cnt < `FPSI_FLASH_ON_TICKS); // RULE_11
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 24'h00_0000;
			tick <= 1'b0;
			flicker <= 1'b0;
			blink <= 1'b0;
			blink_cnt <= 5'h00;
			flash_cnt <= 5'h00;
			flash <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
			flicker <= next_flicker;
			blink <= next_blink;
			blink_cnt <= next_blink_cnt;
			flash_cnt <= next_flash_cnt;
			flash <= next_flash;
		end
	end

endmodule

//--- test/fpsi_checker.sv
// port assertions of the front panel status indicator, bound to its top
`timescale 1ns/1ns
`include "fpsi_consts.svh"
module fpsi_checker #(
	parameter int TICK_CYCLES = 4
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// ports and panel
	input wire logic in_port_link,
	input wire logic in_port_activity,
	input wire logic out_port_link,
	input wire logic out_port_activity,
	input wire logic [6:0] segment,
	input wire logic in_link_led,
	input wire logic out_link_led
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic taken, flick, seen_ctrl, next_seen_ctrl, prev_led;
	int unsigned still, next_still;
	assign taken = hsel && hready && htrans[1];
	assign flick = in_port_link && in_port_activity;
	// any control write may start the panel, so the check glyph is owed only before one
	always_comb begin
		next_seen_ctrl = seen_ctrl || (taken && hwrite && haddr[7:0] == `FPSI_OFF_CTRL);
		next_still = (flick && in_link_led == prev_led) ? still + 1 : 0;
	end
	// cycles the in link led has stood still while traffic flows
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seen_ctrl <= 1'b0;
			still <= 0;
			prev_led <= 1'b0;
		end else begin
			seen_ctrl <= next_seen_ctrl;
			still <= next_still;
			prev_led <= in_link_led;
		end
	end
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase not one wait state");
	a_write_nowait: assert property (taken && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	a_link_dark: assert property (!in_port_link |=> !in_link_led)
		else $error("in led lit without link");
	a_link_lit: assert property (in_port_link && !in_port_activity |=> in_link_led)
		else $error("in led dark on idle link");
	a_out_dark: assert property (!out_port_link |=> !out_link_led)
		else $error("out led lit without link");
	a_out_lit: assert property (out_port_link && !out_port_activity |=> out_link_led)
		else $error("out led dark on idle link");
	a_flicker_rate: assert property (still <= TICK_CYCLES + 2)
		else $error("in led not flickering");
	a_check_glyph: assert property (!seen_ctrl |-> segment == `FPSI_SEG_CHECK)
		else $error("check glyph left early");
	c_read: cover property (taken && !hwrite);
	c_flicker: cover property (flick && still == 1);
	c_started: cover property (seen_ctrl && segment != `FPSI_SEG_CHECK);
endmodule

bind fpsi_top fpsi_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.in_port_link(in_port_link), .in_port_activity(in_port_activity),
	.out_port_link(out_port_link), .out_port_activity(out_port_activity),
	.segment(segment), .in_link_led(in_link_led), .out_link_led(out_link_led)
);

//--- test/fpsi_net_model.sv
// far side stand-in: link and traffic status of both network ports
`timescale 1ns/1ns
module fpsi_net_model (
	// clock
	input wire logic hclk,
	// wanted port state: 0 down, 1 idle link, 2 traffic
	input wire logic [1:0] in_cfg,
	input wire logic [1:0] out_cfg,
	// port status pins
	output logic in_port_link = 1'b0,
	output logic in_port_activity = 1'b0,
	output logic out_port_link = 1'b0,
	output logic out_port_activity = 1'b0
);
	// pins move just after an edge; traffic never shows without a link
	always @(posedge hclk) begin
		in_port_link <= in_cfg != 2'd0;
		in_port_activity <= in_cfg == 2'd2;
		out_port_link <= out_cfg != 2'd0;
		out_port_activity <= out_cfg == 2'd2;
	end
endmodule

//--- test/tb.sv
// self-checking bench of the front panel status indicator
`timescale 1ns/1ns
`include "fpsi_consts.svh"
module tb;
	localparam int TK = 4;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [1:0] htrans = 2'b00;
	logic [1:0] in_cfg = 2'd0;
	logic [1:0] out_cfg = 2'd0;
	logic [3:0] up_sw = 4'ha;
	logic [3:0] lo_sw = 4'h5;
	logic [31:0] hrdata, rd;
	logic [6:0] segment, cur;
	logic hreadyout, hresp, in_lk, in_act, out_lk, out_act;
	logic servo_on_led, run_led, in_link_led, out_link_led, irq;
	int err_total = 0;
	int comparisons = 0;
	int n;
	// net state, servo bits, glyph, run led (2: a pattern, not sampled)
	logic [16:0] rows [11] = '{
		{3'h0, 5'h00, `FPSI_SEG_NOCTRL, 2'd0}, {3'h1, 5'h00, `FPSI_SEG_NOCTRL, 2'd0},
		{3'h2, 5'h00, `FPSI_SEG_PREOP, 2'd2}, {3'h3, 5'h00, `FPSI_SEG_SAFEOP, 2'd2},
		{3'h5, 5'h00, `FPSI_SEG_BOOT, 2'd0}, {3'h4, 5'h00, `FPSI_SEG_SRV_OFF, 2'd1},
		{3'h4, 5'h01, `FPSI_SEG_SRV_RDY, 2'd1}, {3'h4, 5'h03, `FPSI_SEG_SRV_ON, 2'd1},
		{3'h4, 5'h04, `FPSI_SEG_TEST, 2'd1}, {3'h4, 5'h08, `FPSI_SEG_CPU, 2'd1},
		{3'h4, 5'h10, `FPSI_SEG_INIT, 2'd1}
	};
	// alarm code 0x123 detail 4, then back to the preop glyph
	logic [6:0] seq [5] = '{7'h06, 7'h5b, 7'h4f, 7'h66, `FPSI_SEG_PREOP};
	fpsi_top #(.TICK_CYCLES(TK)) i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.upper_address_switch(up_sw), .lower_address_switch(lo_sw),
		.in_port_link(in_lk), .in_port_activity(in_act), .out_port_link(out_lk),
		.out_port_activity(out_act), .segment(segment), .servo_on_led(servo_on_led),
		.run_led(run_led), .in_link_led(in_link_led), .out_link_led(out_link_led), .irq(irq)
	);
	fpsi_net_model i_net (
		.hclk(hclk), .in_cfg(in_cfg), .out_cfg(out_cfg), .in_port_link(in_lk),
		.in_port_activity(in_act), .out_port_link(out_lk), .out_port_activity(out_act)
	);
	// 20 MHz clock
	initial begin
		forever #25 hclk = ~hclk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("counts: %0d compared, %0d mismatched", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// a wait that used up its bound ends the run
	task automatic lim(input int k, input int m);
		if (k >= m) begin
			err_total++;
			wrap_up();
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge hclk);
	endtask
	task automatic rdy;
		int k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		lim(k, 50);
	endtask
	// one single word transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		rdy();
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		rd = hrdata;
	endtask
	function automatic logic pick(input int s);
		return s == 0 ? in_link_led : s == 1 ? run_led : servo_on_led;
	endfunction
	// length of the next whole run of the chosen led at level v
	task automatic run_len(input int s, input logic v, output int len);
		int k = 0;
		len = 0;
		while (pick(s) === v && k < 400) begin
			@(posedge hclk);
			k++;
		end
		while (pick(s) !== v && k < 400) begin
			@(posedge hclk);
			k++;
		end
		while (pick(s) === v && k < 400) begin
			@(posedge hclk);
			k++;
			len++;
		end
		lim(k, 400);
	endtask
	initial begin
		cyc(8);
		chk("reset glyph", `FPSI_SEG_CHECK, segment);
		chk("reset leds", 0, {servo_on_led, run_led, in_link_led, out_link_led, irq});
		hresetn <= 1'b1;
		cyc(1);
		bus(0, `FPSI_OFF_NODE, '0);
		chk("node", 32'h0000_00a5, rd);
		up_sw <= 4'h3;
		lo_sw <= 4'hc;
		bus(0, `FPSI_OFF_NODE, '0);
		chk("node held", 32'h0000_00a5, rd);
		chk("irq masked", 0, irq);
		bus(1, `FPSI_OFF_IRQ_MASK, 32'h1);
		cyc(2);
		chk("irq raised", 1, irq);
		bus(1, `FPSI_OFF_IRQ_STATUS, 32'h1);
		cyc(2);
		chk("irq cleared", 0, irq);
		bus(1, `FPSI_OFF_CTRL, 32'h2);
		cyc(4);
		chk("irq on capture", 1, irq);
		bus(0, `FPSI_OFF_NODE, '0);
		chk("node recaptured", 32'h0000_003c, rd);
		bus(1, 8'h20, 32'hffff_ffff);
		bus(0, 8'h20, '0);
		chk("unmapped", 0, rd);
		$display("test reset and registers done");
		bus(1, `FPSI_OFF_CTRL, 32'h1);
		for (int i = 0; i < 11; i++) begin
			bus(1, `FPSI_OFF_NET, {29'h0, rows[i][16:14]});
			bus(1, `FPSI_OFF_SERVO, {27'h0, rows[i][13:9]});
			bus(0, `FPSI_OFF_PANEL, '0);
			chk("glyph", rows[i][8:2], rd[6:0]);
			if (rows[i][1:0] != 2'd2) begin
				chk("run led", rows[i][1:0], run_led);
			end
			// ready without servo on blinks, so only steady rows are read back
			if (rows[i][13:9] != 5'h01) begin
				chk("servo led", rows[i][13:9] == 5'h03, rd[8]);
			end
		end
		$display("test glyph table done");
		in_cfg <= 2'd2;
		out_cfg <= 2'd1;
		cyc(4);
		chk("out idle link", 1, out_link_led);
		run_len(0, 1'b1, n);
		chk("flicker", TK, n);
		bus(1, `FPSI_OFF_NET, 32'h2);
		run_len(1, 1'b1, n);
		chk("blink", 4 * TK, n);
		bus(1, `FPSI_OFF_NET, 32'h3);
		run_len(1, 1'b1, n);
		chk("flash on", 4 * TK, n);
		run_len(1, 1'b0, n);
		chk("flash off", 20 * TK, n);
		bus(1, `FPSI_OFF_SERVO, 32'h1);
		run_len(2, 1'b1, n);
		chk("servo blink", 4 * TK, n);
		in_cfg <= 2'd0;
		cyc(4);
		chk("in link down", 0, in_link_led);
		chk("out link kept", 1, out_link_led);
		$display("test led patterns done");
		bus(1, `FPSI_OFF_NET, 32'h2);
		bus(1, `FPSI_OFF_ALARM, 32'h0001_1234);
		n = 0;
		while (segment !== `FPSI_SEG_ALARM && n < 1000) begin
			@(posedge hclk);
			n++;
		end
		lim(n, 1000);
		cur = segment;
		// each symbol stands a full step before the next one
		for (int i = 0; i < 5; i++) begin
			n = 0;
			while (segment === cur && n < 200) begin
				@(posedge hclk);
				n++;
			end
			lim(n, 200);
			chk("step length", 20 * TK, n);
			chk("alarm glyph", seq[i], segment);
			cur = segment;
		end
		// clear in mid-sequence so a stuck sequence cannot pass as the net glyph
		n = 0;
		while (segment === `FPSI_SEG_PREOP && n < 200) begin
			@(posedge hclk);
			n++;
		end
		lim(n, 200);
		chk("alarm again", `FPSI_SEG_ALARM, segment);
		bus(1, `FPSI_OFF_ALARM, '0);
		cyc(2);
		chk("alarm cleared", `FPSI_SEG_PREOP, segment);
		hresetn <= 1'b0;
		cyc(2);
		chk("glyph in reset", `FPSI_SEG_CHECK, segment);
		hresetn <= 1'b1;
		cyc(1);
		bus(0, `FPSI_OFF_NODE, '0);
		chk("node after reset", 32'h0000_003c, rd);
		$display("test alarm and reset done");
		wrap_up();
	end
endmodule
